// [verilog/alc_regs.svh]
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: Byte-wide registers addressed by the printed offsets
// Notes:   Definitions only
`ifndef ALC_REGS_SVH
`define ALC_REGS_SVH

// ************************************************************
// Offsets
// ************************************************************
`define ALC_OFF_INT_STAT   8'h02
`define ALC_OFF_INT_MASK   8'h01
`define ALC_OFF_CMP_STAT   8'h30
`define ALC_OFF_CFG1       8'h31
`define ALC_OFF_CFG2       8'h32
`define ALC_OFF_LVL_FIRST  8'h33
`define ALC_OFF_LVL_LAST   8'h3A
`define ALC_OFF_ADC_FIRST  8'h3B

// ************************************************************
// Fields of the channel configuration registers
// ************************************************************
`define ALC_CFG_OFFICE_EN  0
`define ALC_CFG_DARK_EN    1
`define ALC_CFG_SHOT       2
`define ALC_CFG_FILT_LO    4
`define ALC_CFG_FILT_HI    7

// ************************************************************
// Reset values and timing
// ************************************************************
`define ALC_RST_BYTE       8'h00
`define ALC_CONV_NS        80000000
`define ALC_CLK_NS         4
`define ALC_CONV_CYC       (`ALC_CONV_NS / `ALC_CLK_NS)

`endif

// [verilog/alc_pkg.sv]
// Purpose: Types shared by the light comparator block
// Assumes: Used with alc_regs.svh
// Notes:   Types only
package alc_pkg;
  typedef enum logic [1:0] {ALC_OUTDOOR, ALC_OFFICE, ALC_DARK} alc_mode_t;

  typedef struct packed {
    logic [7:0]      cfg;
    logic [7:0][7:0] lvl;
    logic            office_flag;
    logic            dark_flag;
    alc_mode_t       mode;
    logic [3:0]      agree_cnt;
    logic [7:0]      sample;
    logic            irq;
  } alc_chan_t;
endpackage : alc_pkg

// [verilog/alc_top.sv]
// Purpose: Two-channel ambient light comparator with mode interrupt
// Assumes: Samples arrive as bytes on sensor pins from an external converter
// Notes:   One state struct, one comb fill, one register stage
// What this block does
// - Two channels, each feeding two comparators
// - Office flag sets below trip, hysteresis clears
// - Dark flag sets below trip, hysteresis clears
// - Office enable at bit 0 of configs
// - Separate enables; converter runs while any set
// - Disabled channel holds its flags unchanged unless channel one has a single-shot request
// - Flag pair decodes outdoor, office, dark
// - Levels and hysteresis at 0x33 to 0x3A
// - Single-shot request on channel one triggers one measurement
// - Sequencer clears single-shot request itself
// - Each conversion takes 80 ms
// - Filter needs sequential agreeing readings
// - Mode change sets channel status bit
// - Enabled status bit drives interrupt low
// - Status cleared only by writing one
`timescale 1ns/1ps
`include "alc_regs.svh"

module alc_top
  import alc_pkg::*;
#(
  parameter int unsigned CONV_CYC = `ALC_CONV_CYC
)(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] sensor_one_pin,
  input  wire logic [7:0] sensor_two_pin,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            interrupt_out_n
);

  typedef struct packed {
    alc_chan_t [1:0] ch;
    logic [1:0]      mask;
    logic [31:0]     tick_cnt;
    logic [7:0]      rdata;
    logic [7:0]      sync1_a;
    logic [7:0]      sync1_b;
    logic [7:0]      sync2_a;
    logic [7:0]      sync2_b;
  } alc_state_t;

  alc_state_t state_ff;
  alc_state_t nxt_state;

  // Decodes the flag pair into a light mode
  function automatic alc_mode_t decode_mode(input logic dark, input logic office);
    if (dark)
    begin
      return ALC_DARK;
    end
    else if (office)
    begin
      return ALC_OFFICE;
    end
    return ALC_OUTDOOR;
  endfunction : decode_mode

  // Filter setting 0..15 means 1..16 agreeing readings
  function automatic logic [3:0] filt_need(input logic [7:0] cfg);
    return cfg[`ALC_CFG_FILT_HI:`ALC_CFG_FILT_LO];
  endfunction : filt_need

  logic       tick;
  logic [8:0] office_clr;
  logic [8:0] dark_clr;
  logic       new_office;
  logic       new_dark;
  logic       run;
  logic       shot;
  alc_mode_t  new_mode;
  logic [7:0] sample_in;
  logic [2:0] lvl_idx;
  logic [1:0] irq_set;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    nxt_state   = state_ff;
    office_clr  = 9'h000;
    dark_clr    = 9'h000;
    new_office  = 1'b0;
    new_dark    = 1'b0;
    run         = 1'b0;
    shot        = 1'b0;
    new_mode    = ALC_OUTDOOR;
    sample_in   = 8'h00;
    lvl_idx     = 3'h0;
    irq_set     = 2'b00;
    // Pins are not on this clock, two stages before use
    nxt_state.sync1_a = sensor_one_pin;
    nxt_state.sync1_b = sensor_two_pin;
    nxt_state.sync2_a = state_ff.sync1_a;
    nxt_state.sync2_b = state_ff.sync1_b;

    tick = (state_ff.tick_cnt == CONV_CYC - 1);
    nxt_state.tick_cnt = tick ? 32'h0 : state_ff.tick_cnt + 32'h1;

    for (int c = 0; c < 2; c++)
    begin
      sample_in = (c == 0) ? state_ff.sync2_a : state_ff.sync2_b;
      run  = state_ff.ch[c].cfg[`ALC_CFG_OFFICE_EN] | state_ff.ch[c].cfg[`ALC_CFG_DARK_EN];
      shot = (c == 0) && state_ff.ch[c].cfg[`ALC_CFG_SHOT];
      if (tick && (run || shot))
      begin
        nxt_state.ch[c].sample = sample_in;
        new_office = state_ff.ch[c].office_flag;
        new_dark   = state_ff.ch[c].dark_flag;
        office_clr = {1'b0, state_ff.ch[c].lvl[0]} + {1'b0, state_ff.ch[c].lvl[1]};
        dark_clr   = {1'b0, state_ff.ch[c].lvl[2]} + {1'b0, state_ff.ch[c].lvl[3]};
        if (state_ff.ch[c].cfg[`ALC_CFG_OFFICE_EN] || shot)
        begin
          if (sample_in < state_ff.ch[c].lvl[0])
          begin
            new_office = 1'b1;
          end
          else if ({1'b0, sample_in} > office_clr)
          begin
            new_office = 1'b0;
          end
        end
        if (state_ff.ch[c].cfg[`ALC_CFG_DARK_EN] || shot)
        begin
          if (sample_in < state_ff.ch[c].lvl[2])
          begin
            new_dark = 1'b1;
          end
          else if ({1'b0, sample_in} > dark_clr)
          begin
            new_dark = 1'b0;
          end
        end
        new_mode = decode_mode(new_dark, new_office);
        if (new_mode == state_ff.ch[c].mode)
        begin
          nxt_state.ch[c].agree_cnt = 4'h0;
        end
        else if (shot || state_ff.ch[c].agree_cnt >= filt_need(state_ff.ch[c].cfg))
        begin
          nxt_state.ch[c].agree_cnt = 4'h0;
          nxt_state.ch[c].office_flag = new_office;
          nxt_state.ch[c].dark_flag   = new_dark;
          nxt_state.ch[c].mode = new_mode;
          nxt_state.ch[c].irq = 1'b1;
          irq_set[c] = 1'b1;
        end
        else
        begin
          nxt_state.ch[c].agree_cnt = state_ff.ch[c].agree_cnt + 4'h1;
        end
        if (shot)
        begin
          nxt_state.ch[c].cfg[`ALC_CFG_SHOT] = 1'b0;
        end
      end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    if (reg_wr)
    begin
      unique case (reg_addr)
        `ALC_OFF_INT_MASK: nxt_state.mask = reg_wdata[1:0];
        `ALC_OFF_CFG1: nxt_state.ch[0].cfg = reg_wdata;
        `ALC_OFF_CFG2: nxt_state.ch[1].cfg = reg_wdata & 8'hFB;
        `ALC_OFF_INT_STAT:
        begin
          for (int c = 0; c < 2; c++)
          begin
            // A change in the same cycle keeps the bit, even if it was already set
            if (reg_wdata[c] && !irq_set[c])
            begin
              nxt_state.ch[c].irq = 1'b0;
            end
          end
        end
        default:
        begin
          if (reg_addr >= `ALC_OFF_LVL_FIRST && reg_addr <= `ALC_OFF_LVL_LAST)
          begin
            lvl_idx = 3'(reg_addr - `ALC_OFF_LVL_FIRST);
            nxt_state.ch[lvl_idx[2]].lvl[lvl_idx[1:0]] = reg_wdata;
          end
        end
      endcase
    end

    // ************************************************************
    // Register reads, data one cycle later
    // ************************************************************
    nxt_state.rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr >= `ALC_OFF_LVL_FIRST && reg_addr <= `ALC_OFF_LVL_LAST)
      begin
        lvl_idx = 3'(reg_addr - `ALC_OFF_LVL_FIRST);
        nxt_state.rdata = state_ff.ch[lvl_idx[2]].lvl[lvl_idx[1:0]];
      end
      else if (reg_addr == `ALC_OFF_INT_MASK)
      begin
        nxt_state.rdata = {6'h00, state_ff.mask};
      end
      else if (reg_addr == `ALC_OFF_INT_STAT)
      begin
        nxt_state.rdata = {6'h00, state_ff.ch[1].irq, state_ff.ch[0].irq};
      end
      else if (reg_addr == `ALC_OFF_CMP_STAT)
      begin
        nxt_state.rdata = {4'h0, state_ff.ch[1].dark_flag, state_ff.ch[1].office_flag,
                           state_ff.ch[0].dark_flag, state_ff.ch[0].office_flag};
      end
      else if (reg_addr == `ALC_OFF_CFG1)
      begin
        nxt_state.rdata = state_ff.ch[0].cfg;
      end
      else if (reg_addr == `ALC_OFF_CFG2)
      begin
        nxt_state.rdata = state_ff.ch[1].cfg;
      end
      else if (reg_addr == `ALC_OFF_ADC_FIRST)
      begin
        nxt_state.rdata = state_ff.ch[0].sample;
      end
      else if (reg_addr == `ALC_OFF_ADC_FIRST + 8'h01)
      begin
        nxt_state.rdata = state_ff.ch[1].sample;
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign interrupt_out_n = ~|(state_ff.mask & {state_ff.ch[1].irq, state_ff.ch[0].irq});

endmodule : alc_top

// [verif/alc_light_src.sv]
// Purpose: Converter result stand-in for one channel
// Assumes: Result moves at any phase to clk
// Notes:   Holds its value until told otherwise
`timescale 1ns/1ps
module alc_light_src (
  input  wire logic [7:0] level,
  output logic      [7:0] pin = 8'hFF
);
  // one result per channel
  // Skewed off the edge so the synchroniser is exercised
  always @(level) pin <= #1.3 level;
endmodule : alc_light_src

// [verif/alc_top_chk.sv]
// Purpose: Port checker for alc_top
// Assumes: One clock, srst synchronous high
// Notes:   Shadows track a few written bytes
`timescale 1ns/1ps
module alc_top_chk #(
  parameter int unsigned CONV_CYC = 16
)(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       interrupt_out_n
);
  // ************
  // Shadows
  // ************
  logic [1:0] en1_ff;
  logic [1:0] en2_ff;
  logic [7:0] lvl_ff;
  always_ff @(posedge clk)
  begin
    if (srst) {en1_ff, en2_ff, lvl_ff} <= 12'h000;
    else if (reg_wr && reg_addr == 8'h31) en1_ff <= reg_wdata[1:0];
    else if (reg_wr && reg_addr == 8'h32) en2_ff <= reg_wdata[1:0];
    else if (reg_wr && reg_addr == 8'h33) lvl_ff <= reg_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("Read data outside its slot");
  AST_UNMAP: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 8'h00)
    else $error("Unmapped read not zero");
  AST_LVL: assert property (reg_rd && reg_addr == 8'h33 |=> reg_rdata == $past(lvl_ff))
    else $error("Level byte lost");
  AST_CFG1_EN: assert property (reg_rd && reg_addr == 8'h31 |=> reg_rdata[1:0] == $past(en1_ff))
    else $error("Channel one enables lost");
  AST_CFG2_EN: assert property (reg_rd && reg_addr == 8'h32 |=> reg_rdata[1:0] == $past(en2_ff))
    else $error("Channel two enables lost");
  AST_SHOT2: assert property (reg_rd && reg_addr == 8'h32 |=> !reg_rdata[2])
    else $error("Shot bit on channel two");
  AST_RST: assert property ($fell(srst) |-> interrupt_out_n && reg_rdata == 8'h00)
    else $error("Outputs busy after reset");
  AST_IRQ_RISE: assert property ($rose(interrupt_out_n) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("Interrupt released without a write");
  AST_RD_KEEP: assert property (reg_rd && !interrupt_out_n && !$past(reg_wr) && !$past(reg_wr, 2)
    |=> !interrupt_out_n)
    else $error("Read released the interrupt");
  cover property ($fell(interrupt_out_n));
  cover property (reg_wr && reg_addr == 8'h02 && reg_wdata[0]);
  cover property (reg_rd && reg_addr == 8'h30 ##1 reg_rdata != 8'h00);
endmodule : alc_top_chk
bind alc_top alc_top_chk #(.CONV_CYC(CONV_CYC)) u_chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .interrupt_out_n(interrupt_out_n));

// [verif/tb_ambient_light_comparator.sv]
// Purpose: Self-checking bench for the light comparator
// Assumes: Conversion shortened to 16 cycles
// Notes:   Bus driven by NBA after rising edges
`timescale 1ns/1ps
module tb_ambient_light_comparator;
  localparam int CC = 16;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] lvl1 = 8'hFF;
  logic [7:0] lvl2 = 8'hFF;
  logic [7:0] pin1, pin2, reg_rdata;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       interrupt_out_n;
  int         err_total = 0;
  int         check_count = 0;
  logic [7:0] rs [6] = '{8'h31, 8'h32, 8'h30, 8'h02, 8'h01, 8'h20};
  logic [7:0] lv [4] = '{8'h80, 8'h10, 8'h40, 8'h08};
  logic [7:0] hs [4] = '{8'h45, 8'h49, 8'h85, 8'h91};
  logic [7:0] hf [4] = '{8'h03, 8'h01, 8'h01, 8'h00};
  alc_top #(.CONV_CYC(CC)) u_dut (.clk(clk), .srst(srst), .sensor_one_pin(pin1),
    .sensor_two_pin(pin2), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .interrupt_out_n(interrupt_out_n));
  alc_light_src u_src1 (.level(lvl1), .pin(pin1));
  alc_light_src u_src2 (.level(lvl2), .pin(pin2));
  // ************
  // Tasks
  // ************
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk8(reg_rdata, e);
  endtask : rc
  // Waits only whole conversions plus synchroniser slack
  task automatic conv(input int n);
    repeat (n * CC + 4) @(posedge clk);
  endtask : conv
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  initial forever #2 clk = ~clk;
  initial
  begin
    repeat (4000) @(posedge clk);
    err_total++;
    stop_test();
  end
  // ************
  // Tests
  // ************
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    foreach (rs[i]) rc(rs[i], 8'h00);
    for (int i = 0; i < 8; i++) wr(8'(8'h33 + i), lv[i % 4]);
    for (int i = 0; i < 8; i++) rc(8'(8'h33 + i), lv[i % 4]);
    lvl1 <= 8'h20;
    conv(3);
    rc(8'h30, 8'h00);
    wr(8'h01, 8'h03);
    wr(8'h31, 8'h01);
    conv(2);
    rc(8'h30, 8'h01);
    rc(8'h02, 8'h01);
    chk8({7'h00, interrupt_out_n}, 8'h00);
    wr(8'h02, 8'h00);
    rc(8'h02, 8'h01);
    wr(8'h02, 8'h01);
    rc(8'h02, 8'h00);
    chk8({7'h00, interrupt_out_n}, 8'h01);
    wr(8'h31, 8'h03);
    conv(2);
    rc(8'h30, 8'h03);
    foreach (hs[i])
    begin
      lvl1 <= hs[i];
      conv(2);
      rc(8'h30, hf[i]);
      rc(8'h3B, hs[i]);
    end
    wr(8'h02, 8'h01);
    wr(8'h01, 8'h02);
    lvl1 <= 8'h20;
    conv(2);
    rc(8'h02, 8'h01);
    chk8({7'h00, interrupt_out_n}, 8'h01);
    wr(8'h02, 8'h01);
    wr(8'h31, 8'h33);
    lvl1 <= 8'hA0;
    conv(2);
    rc(8'h30, 8'h03);
    conv(4);
    rc(8'h30, 8'h00);
    lvl1 <= 8'h20;
    wr(8'h31, 8'h00);
    wr(8'h31, 8'h04);
    conv(2);
    rc(8'h31, 8'h00);
    rc(8'h30, 8'h03);
    wr(8'h32, 8'h07);
    rc(8'h32, 8'h03);
    wr(8'h01, 8'h03);
    wr(8'h02, 8'h03);
    lvl2 <= 8'h30;
    conv(2);
    rc(8'h30, 8'h0F);
    rc(8'h02, 8'h02);
    chk8({7'h00, interrupt_out_n}, 8'h00);
    stop_test();
  end
endmodule : tb_ambient_light_comparator
